/* File: sfr_cfg.svh */
// Constants of the flash read sequencer: opcodes, fields, defaults, edges
// Included by bare name; defines only
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
`define SFR_OP_WRAP    8'h77
`define SFR_OP_PARAM   8'hc0
`define SFR_OP_QREAD   8'heb
`define SFR_OP_QDTR    8'hed
`define SFR_OP_QREAD4  8'hec
`define SFR_OP_QDTR4   8'hee
`define SFR_OP_WORD    8'he7
`define SFR_OP_BWRAP   8'h0c
`define SFR_WDIS_BIT   4
`define SFR_WLEN_HI    6
`define SFR_WLEN_LO    5
`define SFR_CSEL_HI    5
`define SFR_CSEL_LO    4
`define SFR_DSEL_HI    5
`define SFR_DSEL_LO    4
`define SFR_PLEN_HI    1
`define SFR_PLEN_LO    0
`define SFR_CSEL_CONT  2'b10
`define SFR_WDIS_RST   1'b1
`define SFR_WLEN_RST   2'b00
`define SFR_DSEL_RST   2'b00
`define SFR_OP_EDGE    8'd7
`define SFR_PARAM_EDGE 8'd3
`define SFR_WRAP_EDGE  8'd15
`define SFR_ADDR3_NIB  8'd6
`define SFR_ADDR4_NIB  8'd8
`define SFR_SPI_ADDR0  8'd8
`define SFR_QPI_ADDR0  8'd2
`define SFR_MODE_CLK   8'd2
`define SFR_WORD_DUMMY 8'd2
`define SFR_QUAD_DUMMY 8'd4
`define SFR_SECT_MIN   8'd8
`endif

/* File: sfr_pkg.sv */
// Types of the flash read sequencer
// Constants live in sfr_cfg.svh
package sfr_pkg;
  typedef enum logic [1:0] {
    LK_HEAD = 2'b00,
    LK_BUSY = 2'b01,
    LK_DATA = 2'b10,
    LK_DEAD = 2'b11
  } sfr_link_t;
  typedef enum logic [1:0] {
    RS_NONE  = 2'b00,
    RS_WRAP  = 2'b01,
    RS_PARAM = 2'b10,
    RS_CONT  = 2'b11
  } sfr_res_t;
endpackage

/* File: sfr_seq.sv */
// Flash read sequencer: wrap setting, read parameters, quad reads
// Assumes a host that drives sclk only while cs_n is low
// Operation
// - Wrap setting command steers later quad reads' wrapping
// - Wrapped output starts at given address, cycles inside its section
// - Quad command mode quad reads never wrap; 0Ch wraps instead
// - Continuous read works for 4-byte DTR quad read in quad mode
// - Word read address steps by one per byte unless SPI wrap is on
// - Quad reads run only with the quad enable bit set
// - Select field 10 makes next frame start with the address
// - Any other select value requires the opcode next frame
// - Continuous read reset clears the select state
// - In SPI mode wrap applies to EB, ED, EC, EE, E7
// - Wrap setting kept until a later command sets disable bit
// - Wrap disable bit is one after power on
// - Wrap length 00..11 gives 8, 16, 32, 64 byte sections
// - Parameter command sets dummy count and wrap length in quad mode
// - Parameter command refused in SPI mode
// - Wrap length kept across the switch into quad mode
// - Reset gives 8 byte wrap length and 4 dummy clocks
// - Dummy select 00..11 gives 4, 4, 6, 8 clocks
// - 4-byte DTR quad read honours select 10 opcode skipping
`timescale 1ns/1ns
`include "sfr_cfg.svh"

module sfr_seq
  import sfr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] io_i,
  input  wire logic       quad_command_mode_i,
  input  wire logic       quad_enable_bit_i,
  input  wire logic       reset_cmd_i,
  input  wire logic       cont_read_reset_i,
  output logic      [3:0] io_o,
  output logic      [3:0] io_oe_n_o,
  output logic            wrap_disable_bit_o,
  output logic      [1:0] wrap_length_bits_o,
  output logic      [1:0] dummy_cycle_select_o,
  output logic            cont_mode_o
);

  // System domain state
  logic            cs_m;
  logic            cs_s;
  logic            cs_d;
  logic            cs_rise;
  logic      [7:0] cont_op;
  logic            next_wdis;
  logic      [1:0] next_wlen;
  logic      [1:0] next_dsel;
  logic            next_cont;
  logic      [7:0] next_cop;
  logic            res_wdis;
  logic      [1:0] res_csel;

  // Link domain state
  logic     [15:0] cfg_src;
  logic     [15:0] cfg_m;
  logic     [15:0] cfg_l;
  logic            l_qpi;
  logic            l_qe;
  logic            l_wdis;
  logic      [1:0] l_wlen;
  logic      [1:0] l_dsel;
  logic            l_cont;
  logic      [7:0] l_cop;
  sfr_link_t       state;
  sfr_link_t       next_state;
  logic      [7:0] cnt;
  logic      [7:0] next_cnt;
  logic     [27:0] sh;
  logic     [31:0] hist;
  logic      [7:0] op_q;
  logic      [7:0] next_op;
  logic      [7:0] op_spi;
  logic      [7:0] op_hist;
  logic      [7:0] op_now;
  logic     [31:0] addr;
  logic     [31:0] next_addr;
  logic     [31:0] step_addr;
  logic            nib_lo;
  logic            next_nib_lo;
  logic      [3:0] next_io;
  logic      [3:0] next_oe_n;
  logic            is_four;
  logic            is_read;
  logic            legal;
  logic            has_m;
  logic            wrap_on;
  logic      [7:0] n_nib;
  logic      [7:0] a0;
  logic      [7:0] e_addr;
  logic      [7:0] e_mode;
  logic      [7:0] e_data;
  logic      [7:0] dcnt;
  logic      [7:0] extra;
  logic      [7:0] mask;
  logic     [31:0] mask32;
  sfr_res_t        res_kind;
  sfr_res_t        next_res_kind;
  logic      [7:0] res_byte;
  logic      [7:0] next_res_byte;
  logic      [7:0] res_op;
  logic      [7:0] next_res_op;

  // Frame end seen in the system domain
  assign cs_rise  = cs_s & ~cs_d;
  assign res_wdis = res_byte[`SFR_WDIS_BIT];
  assign res_csel = res_byte[`SFR_CSEL_HI:`SFR_CSEL_LO];

  always_comb
  begin
    next_wdis = wrap_disable_bit_o;
    next_wlen = wrap_length_bits_o;
    next_dsel = dummy_cycle_select_o;
    next_cont = cont_mode_o;
    next_cop  = cont_op;
    if (reset_cmd_i)
    begin
      next_wlen = `SFR_WLEN_RST;
      next_dsel = `SFR_DSEL_RST;
    end
    if (cont_read_reset_i)
      next_cont = 1'b0;
    if (cs_rise)
    begin
      case (res_kind)
        RS_WRAP:
        begin
          next_wdis = res_wdis;
          next_wlen = res_byte[`SFR_WLEN_HI:`SFR_WLEN_LO];
        end
        RS_PARAM:
        begin
          next_dsel = res_byte[`SFR_DSEL_HI:`SFR_DSEL_LO];
          next_wlen = res_byte[`SFR_PLEN_HI:`SFR_PLEN_LO];
        end
        RS_CONT:
        begin
          next_cont = (res_csel == `SFR_CSEL_CONT);
          next_cop  = res_op;
        end
        default:
          next_cont = next_cont;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    cs_m <= cs_n_i;
    cs_s <= cs_m;
    cs_d <= cs_s;
    if (!resetn_i)
    begin
      wrap_disable_bit_o   <= `SFR_WDIS_RST;
      wrap_length_bits_o   <= `SFR_WLEN_RST;
      dummy_cycle_select_o <= `SFR_DSEL_RST;
      cont_mode_o          <= 1'b0;
      cont_op              <= 8'h00;
    end
    else
    begin
      wrap_disable_bit_o   <= next_wdis;
      wrap_length_bits_o   <= next_wlen;
      dummy_cycle_select_o <= next_dsel;
      cont_mode_o          <= next_cont;
      cont_op              <= next_cop;
    end
  end

  // Settings into the link domain, stable while cs_n is low
  assign cfg_src = {cont_op, cont_mode_o, dummy_cycle_select_o,
                    wrap_length_bits_o, wrap_disable_bit_o,
                    quad_enable_bit_i, quad_command_mode_i};

  always_ff @(posedge sclk_i)
  begin
    cfg_m <= cfg_src;
    cfg_l <= cfg_m;
  end

  assign l_qpi  = cfg_l[0];
  assign l_qe   = cfg_l[1];
  assign l_wdis = cfg_l[2];
  assign l_wlen = cfg_l[4:3];
  assign l_dsel = cfg_l[6:5];
  assign l_cont = cfg_l[7];
  assign l_cop  = cfg_l[15:8];

  // Nibble history, first nibble of the frame on top at the eighth edge
  assign hist = {sh, io_i};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_op
      assign op_spi[g] = hist[4 * g];
    end
  endgenerate

  assign op_hist = l_qpi ? hist[31:24] : op_spi;
  assign op_now  = (cnt < 8'd8) ? (l_cont ? l_cop : op_hist) : op_q;
  assign is_four = (op_now == `SFR_OP_QREAD4) || (op_now == `SFR_OP_QDTR4);
  assign is_read = (op_now == `SFR_OP_QREAD) || (op_now == `SFR_OP_QDTR) ||
                   (op_now == `SFR_OP_QREAD4) || (op_now == `SFR_OP_WORD) ||
                   (op_now == `SFR_OP_QDTR4) ||
                   (l_qpi && (op_now == `SFR_OP_BWRAP));
  assign legal   = is_read && l_qe;
  assign has_m   = (op_now != `SFR_OP_BWRAP);
  assign n_nib   = is_four ? `SFR_ADDR4_NIB : `SFR_ADDR3_NIB;
  assign a0      = l_cont ? 8'd0 : (l_qpi ? `SFR_QPI_ADDR0 : `SFR_SPI_ADDR0);
  assign e_addr  = a0 + n_nib - 8'd1;
  assign e_mode  = e_addr + (has_m ? `SFR_MODE_CLK : 8'd0);
  assign e_data  = e_mode + extra;

  // Dummy clock count and wrap section
  always_comb
  begin
    case (l_dsel)
      2'b10:   dcnt = 8'd6;
      2'b11:   dcnt = 8'd8;
      default: dcnt = 8'd4;
    endcase
    if (l_qpi)
      extra = has_m ? (dcnt - `SFR_MODE_CLK) : dcnt;
    else if (op_now == `SFR_OP_WORD)
      extra = `SFR_WORD_DUMMY;
    else
      extra = `SFR_QUAD_DUMMY;
  end

  assign mask      = (`SFR_SECT_MIN << l_wlen) - 8'd1;
  assign mask32    = {24'h000000, mask};
  assign wrap_on   = l_qpi ? (op_q == `SFR_OP_BWRAP)
                           : (!l_wdis && (op_q != `SFR_OP_BWRAP));
  assign step_addr = addr + 32'h1;

  always_comb
  begin
    next_state    = state;
    next_cnt      = (cnt == 8'hff) ? cnt : cnt + 8'd1;
    next_op       = op_q;
    next_addr     = addr;
    next_nib_lo   = nib_lo;
    next_io       = io_o;
    next_oe_n     = io_oe_n_o;
    next_res_kind = (cnt == 8'd0) ? RS_NONE : res_kind;
    next_res_byte = res_byte;
    next_res_op   = res_op;
    case (state)
      LK_HEAD:
      begin
        if (cnt == `SFR_PARAM_EDGE && !l_cont &&
            hist[15:8] == `SFR_OP_PARAM)
        begin
          next_state = LK_DEAD;
          if (l_qpi)
          begin
            next_res_kind = RS_PARAM;
            next_res_byte = hist[7:0];
          end
        end
        else if (cnt == `SFR_OP_EDGE)
        begin
          next_op = op_now;
          if (legal || (!l_qpi && !l_cont && op_now == `SFR_OP_WRAP))
            next_state = LK_BUSY;
          else
            next_state = LK_DEAD;
        end
      end
      LK_BUSY:
      begin
        if (op_q == `SFR_OP_WRAP && cnt == `SFR_WRAP_EDGE)
        begin
          next_res_kind = RS_WRAP;
          next_res_byte = hist[7:0];
          next_state    = LK_DEAD;
        end
      end
      LK_DATA:
      begin
        if (nib_lo)
        begin
          next_io     = addr[3:0];
          next_nib_lo = 1'b0;
          next_addr   = wrap_on
                        ? ((addr & ~mask32) | (step_addr & mask32))
                        : step_addr;
        end
        else
        begin
          next_io     = addr[7:4];
          next_nib_lo = 1'b1;
        end
      end
      default:
        next_state = LK_DEAD;
    endcase
    if ((state == LK_HEAD || state == LK_BUSY) && legal)
    begin
      if (cnt == e_addr)
        next_addr = is_four ? hist : {8'h00, hist[23:0]};
      if (has_m && cnt == e_mode)
      begin
        next_res_kind = RS_CONT;
        next_res_byte = hist[7:0];
        next_res_op   = op_now;
      end
      if (cnt == e_data)
      begin
        next_state  = LK_DATA;
        next_io     = addr[7:4];
        next_oe_n   = 4'h0;
        next_nib_lo = 1'b1;
      end
    end
  end

  // Frame state, cleared whenever cs_n is high
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      state     <= LK_HEAD;
      cnt       <= 8'h00;
      sh        <= 28'h0000000;
      op_q      <= 8'h00;
      addr      <= 32'h00000000;
      nib_lo    <= 1'b0;
      io_o      <= 4'h0;
      io_oe_n_o <= 4'hf;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= hist[27:0];
      op_q      <= next_op;
      addr      <= next_addr;
      nib_lo    <= next_nib_lo;
      io_o      <= next_io;
      io_oe_n_o <= next_oe_n;
    end
  end

  // Frame result, read by the system domain after cs_n rises
  always_ff @(posedge sclk_i)
  begin
    res_kind <= next_res_kind;
    res_byte <= next_res_byte;
    res_op   <= next_res_op;
  end

  sequence s_data_start;
    state != LK_DATA ##1 state == LK_DATA;
  endsequence

  sequence s_hi_shown;
    state == LK_DATA && nib_lo;
  endsequence

  chk_data_start: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    s_data_start |-> (io_oe_n_o == 4'h0 && io_o == addr[7:4] && nib_lo))
    else $error("first nibble not from start address");

  chk_byte_pair: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    s_hi_shown |=> (io_o == $past(addr[3:0]) && !nib_lo))
    else $error("low nibble did not follow high nibble");

  chk_wrap_window: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    (s_hi_shown and wrap_on) |=> (((addr ^ $past(addr)) & ~mask32) == 32'h0))
    else $error("wrapped address left its section");

  chk_addr_step: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    (s_hi_shown and !wrap_on) |=> (addr == $past(addr) + 32'h1))
    else $error("read address did not step by one");

  chk_quad_nowrap: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    (state == LK_DATA && l_qpi && op_q != `SFR_OP_BWRAP) |-> !wrap_on)
    else $error("quad command mode read wrapped");

  chk_qe_gate: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    (!l_qe && cnt > `SFR_OP_EDGE) |-> (state != LK_DATA))
    else $error("read ran without quad enable");

  chk_param_reject: assert property (
    @(posedge sclk_i) disable iff (cs_n_i)
    (cnt > `SFR_PARAM_EDGE && !l_qpi) |-> (res_kind != RS_PARAM))
    else $error("parameter command taken in SPI mode");

  chk_wdis_default: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> (wrap_disable_bit_o == `SFR_WDIS_RST))
    else $error("wrap disable bit not one after reset");

  chk_param_default: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> (wrap_length_bits_o == `SFR_WLEN_RST &&
                         dummy_cycle_select_o == `SFR_DSEL_RST))
    else $error("read parameters not at default after reset");

  chk_wrap_write: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (cs_rise && res_kind == RS_WRAP) |=> (wrap_disable_bit_o == $past(res_wdis)))
    else $error("wrap disable bit not taken from wrap command");

  chk_cont_update: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (cs_rise && res_kind == RS_CONT) |=>
      (cont_mode_o == ($past(res_csel) == `SFR_CSEL_CONT)))
    else $error("continuous mode not set from select field");

  chk_cont_clear: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (cont_read_reset_i && !(cs_rise && res_kind == RS_CONT)) |=> !cont_mode_o)
    else $error("continuous read reset ignored");

endmodule // sfr_seq

/* File: sfr_host.sv */
// Host controller model for the flash link: frames, clocks, capture
// Assumes the bench hands it whole frames; sclk rests low between them
`timescale 1ns/1ns

module sfr_host
(
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] io_o,
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_n_i
);
  logic [7:0] rx[$];

  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o   = 4'h5;
  end

  // Drives tx on edges 0.., then keeps clocking, sampling after edge e
  task automatic run(input logic [3:0] tx[$], input int e, input int n);
    int last;
    last = (n == 0) ? tx.size() - 1 : e + n;
    rx.delete();
    #7;
    cs_n_o = 1'b0;
    for (int k = 0; k <= last; k++)
    begin
      // Released lines toggle so no stale value survives
      io_o = (k < tx.size()) ? tx[k] : ~io_o;
      #15;
      if (n > 0 && k > e)
        rx.push_back({dev_oe_n_i, dev_io_i});
      sclk_o = 1'b1;
      #15;
      sclk_o = 1'b0;
    end
    #15;
    io_o = ~io_o;
    cs_n_o = 1'b1;
  endtask
endmodule // sfr_host

/* File: tb_serial_flash_wrap_and_read_params.sv */
// Bench for the flash read sequencer against a model of its settings
// Assumes sfr_host drives the link; system clock 20 MHz
`timescale 1ns/1ns

module tb_serial_flash_wrap_and_read_params;
  logic       sys_clk_i;
  logic       resetn_i;
  logic       qcm;
  logic       qe;
  logic       rcmd;
  logic       crst;
  logic       sclk;
  logic       cs_n;
  logic [3:0] hio;
  logic [3:0] dio;
  logic [3:0] doe;
  logic       wdis;
  logic [1:0] wlen;
  logic [1:0] dsel;
  logic       cont;
  logic       m_wdis;
  logic [1:0] m_wlen;
  logic [1:0] m_dsel;
  logic       m_cont;
  logic [15:0] seed;
  logic [7:0] ops [5] = '{8'heb, 8'hed, 8'hec, 8'hee, 8'he7};
  int         mismatches = 0;
  int         cmp_count = 0;
  int         cycles = 0;

  sfr_seq DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(hio), .quad_command_mode_i(qcm),
    .quad_enable_bit_i(qe), .reset_cmd_i(rcmd), .cont_read_reset_i(crst),
    .io_o(dio), .io_oe_n_o(doe), .wrap_disable_bit_o(wdis),
    .wrap_length_bits_o(wlen), .dummy_cycle_select_o(dsel),
    .cont_mode_o(cont));
  sfr_host host (.sclk_o(sclk), .cs_n_o(cs_n), .io_o(hio), .dev_io_i(dio),
    .dev_oe_n_i(doe));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cfg_chk();
    check("cfg", {2'b00, wdis, wlen, dsel, cont},
          {2'b00, m_wdis, m_wlen, m_dsel, m_cont});
  endtask

  task automatic op_in(ref logic [3:0] tx[$], input logic [7:0] op);
    if (qcm)
    begin
      tx.push_back(op[7:4]);
      tx.push_back(op[3:0]);
    end
    else
      for (int i = 7; i >= 0; i--)
        tx.push_back({3'b000, op[i]});
  endtask

  // Settings frame; refused kinds leave the model alone
  task automatic cmd(input logic [7:0] op, input logic [7:0] v);
    logic [3:0] tx[$];
    op_in(tx, op);
    if (op == 8'h77)
      repeat (6) tx.push_back(4'h0);
    tx.push_back(v[7:4]);
    tx.push_back(v[3:0]);
    host.run(tx, 0, 0);
    cyc(6);
    if (op == 8'h77 && !qcm)
      {m_wlen, m_wdis} = v[6:4];
    if (op == 8'hc0 && qcm)
      {m_dsel, m_wlen} = {v[5:4], v[1:0]};
  endtask

  // Read frame of nb bytes, each byte the low address bits
  task automatic rd(input logic [7:0] op, input logic [31:0] a,
                    input logic [7:0] md, input bit cn, input bit ok,
                    input int nb);
    logic [3:0] tx[$];
    logic [7:0] b;
    logic [7:0] mk;
    int         n;
    int         e;
    bit         wr;
    n = (op == 8'hec || op == 8'hee) ? 8 : 6;
    if (!cn)
      op_in(tx, op);
    for (int i = n - 1; i >= 0; i--)
      tx.push_back(a[4*i +: 4]);
    if (op != 8'h0c)
    begin
      tx.push_back(md[7:4]);
      tx.push_back(md[3:0]);
    end
    e = (cn ? 0 : (qcm ? 2 : 8)) + n - 1 + (op != 8'h0c ? 2 : 0);
    if (!qcm)
      e += (op == 8'he7) ? 2 : 4;
    else
      e += (m_dsel == 2'b11 ? 8 : m_dsel == 2'b10 ? 6 : 4)
           - (op == 8'h0c ? 0 : 2);
    host.run(tx, e, 2 * nb);
    wr = qcm ? (op == 8'h0c) : !m_wdis;
    mk = (8'h08 << m_wlen) - 8'h01;
    b = a[7:0];
    for (int i = 0; i < nb; i++)
    begin
      if (ok)
      begin
        check("hi", host.rx[2*i], {4'h0, b[7:4]});
        check("lo", host.rx[2*i+1], {4'h0, b[3:0]});
      end
      else
        check("oe", host.rx[2*i] & 8'hf0, 8'hf0);
      b = wr ? ((b & ~mk) | ((b + 8'h01) & mk)) : b + 8'h01;
    end
    cyc(6);
    if (ok && op != 8'h0c)
      m_cont = (md[5:4] == 2'b10);
    cfg_chk();
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      test_done();
    end
  end

  initial
  begin
    resetn_i = 1'b0;
    qcm = 1'b0;
    qe = 1'b1;
    rcmd = 1'b0;
    crst = 1'b0;
    seed = 16'h000f;
    {m_wdis, m_wlen, m_dsel, m_cont} = 6'b100000;
    cyc(4);
    resetn_i <= 1'b1;
    cyc(4);
    cfg_chk();
    seed = lfsr(seed);
    rd(8'he7, {16'h0, seed[15:1], 1'b0}, 8'h00, 0, 1, 9);
    qe <= 1'b0;
    cyc(4);
    rd(8'he7, 32'h0000_0040, 8'h00, 0, 0, 2);
    qe <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      seed = lfsr(seed);
      cmd(8'h77, {1'b0, i[1:0], 5'h00});
      cfg_chk();
      rd(ops[i], {16'h0, seed[15:1], 1'b0}, 8'h00, 0, 1,
         (8 << i[1:0]) + 3);
    end
    rd(8'he7, 32'h0000_1234, 8'h20, 0, 1, 3);
    rd(8'he7, 32'h0000_5678, 8'h00, 1, 1, 3);
    rd(8'he7, 32'h0000_9abc, 8'h20, 0, 1, 3);
    crst <= 1'b1;
    cyc(1);
    crst <= 1'b0;
    m_cont = 1'b0;
    cyc(4);
    cfg_chk();
    rd(8'he7, 32'h0000_3456, 8'h30, 0, 1, 3);
    cmd(8'h77, 8'h10);
    rd(8'heb, 32'h0000_003e, 8'h00, 0, 1, 6);
    cmd(8'hc0, 8'h33);
    cfg_chk();
    rd(8'h0c, 32'h0000_0100, 8'h00, 0, 0, 2);
    cmd(8'h77, 8'h60);
    qcm <= 1'b1;
    cyc(4);
    cfg_chk();
    cmd(8'h77, 8'h10);
    cfg_chk();
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      cmd(8'hc0, {2'b00, i[1:0], 2'b00, ~i[1:0]});
      cfg_chk();
      rd(8'heb, {16'h0, seed}, 8'h00, 0, 1, 10);
      rd(8'h0c, {16'h0, seed}, 8'h00, 0, 1,
         (8 << (3 - i)) + 2);
    end
    rd(8'hee, 32'h1234_5670, 8'h20, 0, 1, 3);
    rd(8'hee, 32'h0000_0100, 8'h00, 1, 1, 3);
    rcmd <= 1'b1;
    cyc(1);
    rcmd <= 1'b0;
    {m_wlen, m_dsel} = 4'h0;
    cyc(4);
    cfg_chk();
    test_done();
  end
endmodule // tb_serial_flash_wrap_and_read_params
